// ### hdl/als_alu_slice.sv
`timescale 1ns/1ps
module als_alu_slice #(
   parameter int DATA_W = als_pkg::DATA_W,
   parameter int ADDR_W = als_pkg::ADDR_W
) (
   input  wire logic              sys_clk,           // 50 MHz system clock
   input  wire logic              reset,             // Async reset, active high
   input  wire logic [ADDR_W-1:0] register_select,   // Source in high phase, destination in low
   input  wire logic [2:0]        instruction,       // Operation code, read in low phase
   input  wire logic [DATA_W-1:0] operand_bus,       // Operand, read in low phase
   input  wire logic              operation_gate_n,  // Low enables the operation
   output logic                   phase_high,        // High during the source-address phase
   output logic      [DATA_W-1:0] result_out,        // Output register
   output logic                   flag_zero,         // Result all zero
   output logic                   flag_negative,     // Result top bit
   output logic                   flag_overflow,     // Signed overflow of the add
   output logic                   flag_carry         // Carry out of the add
);
   localparam int NUM_REGS = 1 << ADDR_W;

   // The flag logic assumes a slice at least two bits wide
   if (DATA_W < 2 || ADDR_W < 1) begin : g_bad_width
      $error("als_alu_slice: DATA_W must be >= 2 and ADDR_W >= 1");
   end

   als_pkg::als_phase_type phase_ff;
   logic [ADDR_W-1:0]      src_addr_ff;
   logic [DATA_W-1:0]      out_ff;
   logic                   zero_ff, neg_ff, ovf_ff, carry_ff;
   logic [DATA_W-1:0]      src_data;
   logic [DATA_W-1:0]      inv_operand;
   logic [DATA_W:0]        sum;
   logic [DATA_W-1:0]      nxt_result;
   logic                   nxt_ovf, nxt_carry;
   logic                   accum_mode;
   logic                   cycle_end;
   logic                   wr_en;
   logic [ADDR_W-1:0]      wr_addr;

   // Phase generator: each microcycle is one high and one low sys_clk period
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         phase_ff <= als_pkg::PH_HIGH;
      end else begin
         unique case (phase_ff)
            als_pkg::PH_HIGH: phase_ff <= als_pkg::PH_LOW;
            als_pkg::PH_LOW:  phase_ff <= als_pkg::PH_HIGH;
         endcase
      end
   end

   assign phase_high = (phase_ff == als_pkg::PH_HIGH);
   assign cycle_end  = (phase_ff == als_pkg::PH_LOW);

   // Source address is latched in the high phase so the bus can carry the destination later
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         src_addr_ff <= als_pkg::ADDR_RST;
      end else if (phase_high) begin
         src_addr_ff <= register_select;
      end
   end

   // Destination is the bus value during the low phase
   assign accum_mode = (src_addr_ff == register_select);

   // Operation decode
   assign inv_operand = ~operand_bus;
   assign sum = {1'b0, src_data} + {1'b0, inv_operand}
                + {{DATA_W{1'b0}}, (instruction == als_pkg::OP_ADD_INC)};

   always_comb begin
      nxt_result = src_data;
      nxt_ovf    = 1'b0;
      nxt_carry  = 1'b0;
      unique case (instruction)
         als_pkg::OP_ADD_INC, als_pkg::OP_ADD: begin
            nxt_result = sum[DATA_W-1:0];
            nxt_carry  = sum[DATA_W];
            nxt_ovf    = (src_data[DATA_W-1] == inv_operand[DATA_W-1]) &&
                         (sum[DATA_W-1] != src_data[DATA_W-1]);
         end
         als_pkg::OP_AND:    nxt_result = src_data & inv_operand;
         als_pkg::OP_LOAD_N: nxt_result = inv_operand;
         als_pkg::OP_READ:   nxt_result = src_data;
         als_pkg::OP_OR:     nxt_result = src_data | inv_operand;
         als_pkg::OP_XOR:    nxt_result = src_data ^ inv_operand;
         als_pkg::OP_LOAD:   nxt_result = operand_bus;
      endcase
   end

   // Register write: accumulator mode targets the source, a read in that mode writes nothing
   assign wr_addr = accum_mode ? src_addr_ff : register_select;
   assign wr_en   = cycle_end && !operation_gate_n &&
                    !(accum_mode && (instruction == als_pkg::OP_READ));

   als_reg_bank #(
      .DATA_W (DATA_W),
      .ADDR_W (ADDR_W),
      .DEPTH  (NUM_REGS)
   ) u_bank (
      .sys_clk (sys_clk),
      .reset   (reset),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (nxt_result),
      .rd_addr (src_addr_ff),
      .rd_data (src_data)
   );

   // Output register loads on the edge ending the cycle, only while the gate is low
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         out_ff <= als_pkg::OUT_RST;
      end else if (cycle_end && !operation_gate_n) begin
         out_ff <= nxt_result;
      end
   end

   // Flags move with the output register so the sequencer sees a matched set
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         zero_ff  <= 1'b1;
         neg_ff   <= 1'b0;
         ovf_ff   <= 1'b0;
         carry_ff <= 1'b0;
      end else if (cycle_end && !operation_gate_n) begin
         zero_ff  <= (nxt_result == '0);
         neg_ff   <= nxt_result[DATA_W-1];
         ovf_ff   <= nxt_ovf;
         carry_ff <= nxt_carry;
      end
   end

   assign result_out    = out_ff;
   assign flag_zero     = zero_ff;
   assign flag_negative = neg_ff;
   assign flag_overflow = ovf_ff;
   assign flag_carry    = carry_ff;  // Held a full microcycle for the sequencer

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic gated_end;
   assign gated_end = cycle_end && !operation_gate_n;

   sequence s_high_phase;
      phase_high;
   endsequence
   sequence s_low_phase;
      !phase_high;
   endsequence

   property p_phase_alternate;
      s_high_phase |=> s_low_phase ##1 s_high_phase;
   endproperty
   a_phase_alternate: assert property (p_phase_alternate) else $error("phase did not alternate");

   property p_src_capture;
      phase_high |=> src_addr_ff == $past(register_select);
   endproperty
   a_src_capture: assert property (p_src_capture) else $error("source address not latched");

   property p_out_load;
      gated_end |=> out_ff == $past(nxt_result);
   endproperty
   a_out_load: assert property (p_out_load) else $error("output register missed result");

   property p_out_hold;
      !gated_end |=> $stable(out_ff);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output register changed while idle");

   property p_accum_target;
      gated_end && accum_mode && instruction != als_pkg::OP_READ |-> wr_en && wr_addr == src_addr_ff;
   endproperty
   a_accum_target: assert property (p_accum_target) else $error("accumulator write misdirected");

   property p_general_target;
      gated_end && !accum_mode |-> wr_en && wr_addr == register_select;
   endproperty
   a_general_target: assert property (p_general_target) else $error("general write misdirected");

   property p_read_nowrite;
      accum_mode && instruction == als_pkg::OP_READ |-> !wr_en;
   endproperty
   a_read_nowrite: assert property (p_read_nowrite) else $error("read wrote a register");

   property p_add_inc;
      gated_end && instruction == als_pkg::OP_ADD_INC |=>
         out_ff == $past(DATA_W'(src_data + ~operand_bus + 1'b1));
   endproperty
   a_add_inc: assert property (p_add_inc) else $error("add with increment wrong");

   property p_load_true;
      gated_end && instruction == als_pkg::OP_LOAD |=> out_ff == $past(operand_bus);
   endproperty
   a_load_true: assert property (p_load_true) else $error("true load wrong");

   property p_xor;
      gated_end && instruction == als_pkg::OP_XOR |=> out_ff == $past(src_data ^ ~operand_bus);
   endproperty
   a_xor: assert property (p_xor) else $error("xor wrong");

   property p_flags_match;
      flag_zero == (out_ff == '0) && flag_negative == out_ff[DATA_W-1];
   endproperty
   a_flags_match: assert property (p_flags_match) else $error("zero or negative flag mismatch");

   property p_flag_stable;
      !gated_end |=> $stable(flag_carry) && $stable(flag_overflow);
   endproperty
   a_flag_stable: assert property (p_flag_stable) else $error("flags changed mid cycle");
endmodule // als_alu_slice

// ### hdl/als_pkg.sv
// Summary of operation
// - Equal source and destination select accumulator mode; unequal selects general register mode.
// - Source register address is taken during the high phase of each cycle.
// - Destination register address is taken during the low phase of each cycle.
// - Output register loads the current result at the end of each cycle in which operation gate is low.
// - LLL adds source, inverted operand and one; LLH adds without the one.
// - LHL writes source AND inverted operand to the target register.
// - LHH loads the inverted operand into the target register.
// - HLL copies source to output only, or to destination in general mode.
// - HLH writes source OR inverted operand to the target register.
// - HHL writes source XOR inverted operand to the target register.
// - HHH loads the true operand into the target register.
// - Zero and negative flags come from each result; overflow and carry come from LLL and LLH and are cleared for every other code.
// - The register file holds eight registers chosen by a three-bit address.
// - The output register captures the result on the edge ending the cycle.
package als_pkg;
   localparam int DATA_W   = 4;
   localparam int ADDR_W   = 3;
   localparam int NUM_REGS = 8;

   // Instruction codes, L=0 H=1
   localparam logic [2:0] OP_ADD_INC = 3'h0;
   localparam logic [2:0] OP_ADD     = 3'h1;
   localparam logic [2:0] OP_AND     = 3'h2;
   localparam logic [2:0] OP_LOAD_N  = 3'h3;
   localparam logic [2:0] OP_READ    = 3'h4;
   localparam logic [2:0] OP_OR      = 3'h5;
   localparam logic [2:0] OP_XOR     = 3'h6;
   localparam logic [2:0] OP_LOAD    = 3'h7;

   // Reset values
   localparam logic [DATA_W-1:0] OUT_RST  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
   localparam logic [DATA_W-1:0] REG_RST  = 4'h0;

   // Two halves of a microcycle
   typedef enum logic {PH_HIGH, PH_LOW} als_phase_type;
endpackage

// ### hdl/als_reg_bank.sv
`timescale 1ns/1ps
module als_reg_bank #(
   parameter int DATA_W = 4,
   parameter int ADDR_W = 3,
   parameter int DEPTH  = 8
) (
   input  wire logic              sys_clk,  // System clock
   input  wire logic              reset,    // Async reset, active high
   input  wire logic              wr_en,    // Write strobe
   input  wire logic [ADDR_W-1:0] wr_addr,  // Write index
   input  wire logic [DATA_W-1:0] wr_data,  // Write word
   input  wire logic [ADDR_W-1:0] rd_addr,  // Read index
   output logic      [DATA_W-1:0] rd_data   // Read word
);
   logic [DATA_W-1:0] mem_ff [DEPTH];

   // Every address must reach a word
   if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
      $error("als_reg_bank: DEPTH must equal 2**ADDR_W");
   end

   // One flop word per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            mem_ff[i] <= als_pkg::REG_RST;
         end else if (wr_en && (wr_addr == ADDR_W'(i))) begin
            mem_ff[i] <= wr_data;
         end
      end
   end

   assign rd_data = mem_ff[rd_addr];
endmodule // als_reg_bank

// ### tb/als_seq_model.sv
`timescale 1ns/1ps
module als_seq_model (
   input  wire logic       sys_clk,           // System clock
   input  wire logic       phase_high,        // Phase seen from the slice
   input  wire logic [2:0] src,               // Source field
   input  wire logic [2:0] dst,               // Destination field
   input  wire logic [2:0] code,              // Instruction field
   input  wire logic [3:0] data,              // Operand field
   input  wire logic       gate_n,            // Gate field, low runs
   input  wire logic [3:0] flags,             // Zero, negative, overflow, carry
   output logic      [2:0] register_select,   // Address to the slice
   output logic      [2:0] instruction,       // Code to the slice
   output logic      [3:0] operand_bus,       // Operand to the slice
   output logic            operation_gate_n,  // Gate to the slice
   output logic      [3:0] test_reg           // Captured flags
);
   // Idle, blocked control word at time zero
   initial begin
      register_select  = 3'h0;
      instruction      = 3'h0;
      operand_bus      = 4'h0;
      operation_gate_n = 1'b1;
      test_reg         = 4'h0;
   end

   // Address follows the phase; other fields carry junk in the high phase so a slice reading them early fails
   always @(negedge sys_clk) begin
      register_select  <= phase_high ? src : dst;
      instruction      <= phase_high ? ~code : code;
      operand_bus      <= phase_high ? ~data : data;
      operation_gate_n <= phase_high ? ~gate_n : gate_n;
   end

   // Flags hold through the high phase, so take them at its closing edge
   always @(posedge sys_clk) begin
      if (phase_high) test_reg <= flags;
   end
endmodule // als_seq_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %h seen %h", n, e, s); end end
module tb_top;
   logic       sys_clk = 1'b0;
   logic       reset   = 1'b1;
   logic [2:0] src     = 3'h0;
   logic [2:0] dst     = 3'h0;
   logic [2:0] code    = 3'h0;
   logic [3:0] data    = 4'h0;
   logic       gate_n  = 1'b1;
   logic [2:0] register_select, instruction;
   logic [3:0] operand_bus, result_out, test_reg, flg;
   logic       operation_gate_n, phase_high, flag_zero, flag_negative, flag_overflow, flag_carry;
   logic [3:0] er [8];  // Expected register file
   logic [3:0] eo, ef;  // Expected output and flags
   int         mismatches = 0;
   int         num_checks = 0;

   assign flg = {flag_zero, flag_negative, flag_overflow, flag_carry};

   // 50 MHz clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   als_alu_slice u_als_alu_slice (.sys_clk, .reset, .register_select, .instruction, .operand_bus,
      .operation_gate_n, .phase_high, .result_out, .flag_zero, .flag_negative, .flag_overflow, .flag_carry);
   als_seq_model u_als_seq_model (.sys_clk, .phase_high, .src, .dst, .code, .data, .gate_n, .flags(flg),
      .register_select, .instruction, .operand_bus, .operation_gate_n, .test_reg);

   task automatic end_sim;
      if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Two cycles of reset, cleared state checked, then step into the low phase
   task automatic t_reset;
      @(negedge sys_clk);
      reset = 1'b1;
      gate_n = 1'b1;  // A gate left low would replay the last operation right after release
      repeat (2) @(negedge sys_clk);
      `CHK("res", 4'h0, result_out) // Output cleared
      `CHK("flg", 4'h8, flg) // Zero flag set
      `CHK("ph", 1'b1, phase_high) // Source phase first
      foreach (er[k]) er[k] = 4'h0;
      eo = 4'h0;
      ef = 4'h8;
      reset = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   // One microcycle; the next one may follow at once since it returns inside a high phase
   task automatic do_op(input logic [2:0] s, d, c, input logic [3:0] v, input logic g);
      logic [4:0] sum;
      logic [3:0] a, b, r;
      repeat (3) if (phase_high !== 1'b1) begin
         @(posedge sys_clk);
         #1;
      end
      `CHK("sync", 1'b1, phase_high) // Bounded wait for the source phase
      if (phase_high !== 1'b1) end_sim();
      src = s;
      dst = d;
      code = c;
      data = v;
      gate_n = g;
      a = er[s];
      b = ~v;
      sum = {1'b0, a} + {1'b0, b} + {4'h0, c == 3'h0};
      case (c)
         3'h0, 3'h1: r = sum[3:0];
         3'h2: r = a & b;
         3'h3: r = b;
         3'h4: r = a;
         3'h5: r = a | b;
         3'h6: r = a ^ b;
         default: r = v;
      endcase
      if (!g) begin
         eo = r;
         ef = {r == 4'h0, r[3], c < 3'h2 && a[3] == b[3] && r[3] != a[3], c < 3'h2 && sum[4]};
         if (c != 3'h4 || s != d) er[s == d ? s : d] = r;
      end
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("res", eo, result_out) // Output register
      `CHK("flg", ef, flg) // Status flags
   endtask

   // Load all eight registers, then read each back
   task automatic t_fill;
      for (int k = 0; k < 8; k++) do_op(k[2:0], k[2:0], 3'h7, 4'h9 + k[3:0], 1'b0); // True load
      for (int k = 0; k < 8; k++) do_op(k[2:0], k[2:0], 3'h4, 4'h0, 1'b0); // Read only
   endtask

   // Every code in both modes; general writes must spare the source
   task automatic t_codes;
      for (int c = 0; c < 8; c++) begin
         do_op(3'h1, 3'h6, c[2:0], 4'h3, 1'b0); // General
         do_op(3'h6, 3'h6, 3'h4, 4'h0, 1'b0); // Destination
         do_op(3'h1, 3'h1, 3'h4, 4'h0, 1'b0); // Source kept
         do_op(3'h3, 3'h3, c[2:0], 4'h6, 1'b0); // Accumulator
      end
   endtask

   // Gate high blocks writes and holds output and flags
   task automatic t_gate;
      do_op(3'h2, 3'h5, 3'h7, 4'h4, 1'b1); // Blocked load
      do_op(3'h5, 3'h5, 3'h4, 4'h0, 1'b0); // Destination kept
   endtask

   // Zero result, then the captured test register
   task automatic t_flags;
      do_op(3'h4, 3'h4, 3'h3, 4'hf, 1'b0); // Zero load
      @(posedge sys_clk);
      #1;
      `CHK("tst", ef, test_reg) // Flags captured
   endtask

   initial begin
      t_reset();
      t_fill();
      t_codes();
      t_gate();
      t_flags();
      t_reset();
      do_op(3'h5, 3'h5, 3'h4, 4'h0, 1'b0); // Cleared register
      end_sim();
   end
endmodule // tb_top
